// ===== src/rcef_cfg.svh
// register offsets, reset values and field positions of the radio event flag block
// assumes a 32-bit register port addressed directly by byte offsets
`ifndef RCEF_CFG_SVH
`define RCEF_CFG_SVH
`define RCEF_ADDR_W 12
`define RCEF_OFF_CRC_GOOD 12'h130
`define RCEF_OFF_CRC_FAIL 12'h134
`define RCEF_OFF_FRAME_LEN 12'h138
`define RCEF_OFF_ED_DONE 12'h13C
`define RCEF_OFF_ED_HALT 12'h140
`define RCEF_OFF_CH_IDLE 12'h144
`define RCEF_OFF_CH_BUSY 12'h148
`define RCEF_OFF_IRQ_STATUS 12'h300
`define RCEF_OFF_IRQ_CLEAR 12'h304
`define RCEF_OFF_IRQ_ENABLE 12'h308
`define RCEF_NUM_EVENTS 7
`define RCEF_FLAG_BIT 0
`define RCEF_FLAG_RESET 1'h0
`define RCEF_IRQ_RESET 7'h00
`endif

// ===== src/rcef_pkg.sv
// types shared by the radio event flag block
// assumes rcef_cfg.svh supplies the event count
`include "rcef_cfg.svh"
package rcef_pkg;
    typedef logic [`RCEF_NUM_EVENTS-1:0] rcef_vec_t;
    typedef logic [`RCEF_ADDR_W-1:0] rcef_addr_t;
endpackage

// ===== src/rcef_ev_if.sv
// event, clear and write vectors carried from the top to the flag bank, flags carried back
// assumes one clock domain
interface rcef_ev_if;
    rcef_pkg::rcef_vec_t set;
    rcef_pkg::rcef_vec_t clr;
    rcef_pkg::rcef_vec_t wval;
    rcef_pkg::rcef_vec_t flags;
    modport bank (input set, input clr, input wval, output flags);
    modport ctrl (output set, output clr, output wval, input flags);
endinterface

// ===== src/rcef_flag_bank.sv
// bank of sticky one-bit event flags
// assumes synchronous reset copy from the top, active low
`include "rcef_cfg.svh"
module rcef_flag_bank (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // flag control
    rcef_ev_if.bank ev
);
    rcef_pkg::rcef_vec_t flag_reg;
    rcef_pkg::rcef_vec_t flag_next;

    genvar i;
    generate
        for (i = 0; i < `RCEF_NUM_EVENTS; i = i + 1) begin : g_flag
            always_comb begin
                // set wins over a same-cycle write
                if (ev.set[i]) begin
                    flag_next[i] = 1'b1;
                end else if (ev.clr[i]) begin
                    flag_next[i] = ev.wval[i];
                end else begin
                    flag_next[i] = flag_reg[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_reg <= {`RCEF_NUM_EVENTS{`RCEF_FLAG_RESET}};
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign ev.flags = flag_reg;
endmodule

// ===== src/rcef_top.sv
// radio event flags with register port and interrupt
// assumes event inputs are one-cycle pulses from logic on clk
//
// The address-and-strobe port was chosen for this implementation.
`include "rcef_cfg.svh"
// Functional notes
// - good-crc packet received sets flag at 0x130 bit 0.
// - failed-crc packet received sets flag at 0x134 bit 0.
// - frame length field received sets flag at 0x138 bit 0.
// - energy detection sampling complete sets flag at 0x13C bit 0.
// - energy detection sampling halted sets flag at 0x140 bit 0.
// - channel found idle sets flag at 0x144 bit 0.
// - channel found busy sets flag at 0x148 bit 0.
module rcef_top (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // register port
    input wire logic [`RCEF_ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // radio events, one-cycle pulses
    input wire logic crc_good_pulse,
    input wire logic crc_fail_pulse,
    input wire logic frame_length_pulse,
    input wire logic energy_done_pulse,
    input wire logic energy_halt_pulse,
    input wire logic channel_idle_pulse,
    input wire logic channel_busy_pulse,
    // interrupt
    output logic irq
);
    logic rst_meta_reg;
    logic rst_n_reg;
    rcef_pkg::rcef_vec_t sts_reg;
    rcef_pkg::rcef_vec_t sts_next;
    rcef_pkg::rcef_vec_t en_reg;
    rcef_pkg::rcef_vec_t en_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic irq_reg;
    logic irq_next;
    rcef_pkg::rcef_vec_t ev_pulse;
    rcef_pkg::rcef_vec_t wsel;
    logic [31:0] rd_val;

    rcef_ev_if evi ();

    // reset release through two flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    assign ev_pulse = {channel_busy_pulse, channel_idle_pulse, energy_halt_pulse,
                       energy_done_pulse, frame_length_pulse, crc_fail_pulse,
                       crc_good_pulse};

    // write decode of flag registers
    always_comb begin
        wsel = '0;
        if (wr) begin
            if (addr == `RCEF_OFF_CRC_GOOD) begin
                wsel[0] = 1'b1;
            end else if (addr == `RCEF_OFF_CRC_FAIL) begin
                wsel[1] = 1'b1;
            end else if (addr == `RCEF_OFF_FRAME_LEN) begin
                wsel[2] = 1'b1;
            end else if (addr == `RCEF_OFF_ED_DONE) begin
                wsel[3] = 1'b1;
            end else if (addr == `RCEF_OFF_ED_HALT) begin
                wsel[4] = 1'b1;
            end else if (addr == `RCEF_OFF_CH_IDLE) begin
                wsel[5] = 1'b1;
            end else if (addr == `RCEF_OFF_CH_BUSY) begin
                wsel[6] = 1'b1;
            end
        end
    end

    assign evi.set = ev_pulse;
    assign evi.clr = wsel;
    assign evi.wval = {`RCEF_NUM_EVENTS{wdata[`RCEF_FLAG_BIT]}};

    rcef_flag_bank u_bank (
        .clk(clk),
        .rst_n(rst_n_reg),
        .ev(evi.bank)
    );

    // read mux, unmapped reads zero
    always_comb begin
        rd_val = 32'h00000000;
        if (addr == `RCEF_OFF_CRC_GOOD) begin
            rd_val[`RCEF_FLAG_BIT] = evi.flags[0];
        end else if (addr == `RCEF_OFF_CRC_FAIL) begin
            rd_val[`RCEF_FLAG_BIT] = evi.flags[1];
        end else if (addr == `RCEF_OFF_FRAME_LEN) begin
            rd_val[`RCEF_FLAG_BIT] = evi.flags[2];
        end else if (addr == `RCEF_OFF_ED_DONE) begin
            rd_val[`RCEF_FLAG_BIT] = evi.flags[3];
        end else if (addr == `RCEF_OFF_ED_HALT) begin
            rd_val[`RCEF_FLAG_BIT] = evi.flags[4];
        end else if (addr == `RCEF_OFF_CH_IDLE) begin
            rd_val[`RCEF_FLAG_BIT] = evi.flags[5];
        end else if (addr == `RCEF_OFF_CH_BUSY) begin
            rd_val[`RCEF_FLAG_BIT] = evi.flags[6];
        end else if (addr == `RCEF_OFF_IRQ_STATUS) begin
            rd_val[`RCEF_NUM_EVENTS-1:0] = sts_reg;
        end else if (addr == `RCEF_OFF_IRQ_ENABLE) begin
            rd_val[`RCEF_NUM_EVENTS-1:0] = en_reg;
        end
    end

    // interrupt status, enable and read data
    always_comb begin
        sts_next = sts_reg;
        en_next = en_reg;
        if (wr && addr == `RCEF_OFF_IRQ_CLEAR) begin
            sts_next = sts_reg & ~wdata[`RCEF_NUM_EVENTS-1:0];
        end
        sts_next = sts_next | ev_pulse;
        if (wr && addr == `RCEF_OFF_IRQ_ENABLE) begin
            en_next = wdata[`RCEF_NUM_EVENTS-1:0];
        end
        irq_next = |(sts_next & en_next);
        rdata_next = rd ? rd_val : 32'h00000000;
    end

    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            sts_reg <= `RCEF_IRQ_RESET;
            en_reg <= `RCEF_IRQ_RESET;
            irq_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
        end else begin
            sts_reg <= sts_next;
            en_reg <= en_next;
            irq_reg <= irq_next;
            rdata_reg <= rdata_next;
        end
    end

    assign rdata = rdata_reg;
    assign irq = irq_reg;
endmodule

// ===== tb/rcef_checker.sv
// port checker of the radio event flag block
// assumes rcef_top ports and rcef_cfg.svh offsets
`include "rcef_cfg.svh"
module rcef_chk (
    // clock, reset, register port
    input wire logic clk,
    input wire logic resetn,
    input wire logic [`RCEF_ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    // radio events
    input wire logic crc_good_pulse,
    input wire logic crc_fail_pulse,
    input wire logic frame_length_pulse,
    input wire logic energy_done_pulse,
    input wire logic energy_halt_pulse,
    input wire logic channel_idle_pulse,
    input wire logic channel_busy_pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_rd(logic [11:0] a); rd && addr == a; endsequence
    property p_good; crc_good_pulse ##1 s_rd(`RCEF_OFF_CRC_GOOD) |=> rdata[0]; endproperty
    a_good: assert property (p_good) else $error("crc good flag");
    property p_fail; crc_fail_pulse ##1 s_rd(`RCEF_OFF_CRC_FAIL) |=> rdata[0]; endproperty
    a_fail: assert property (p_fail) else $error("crc fail flag");
    property p_len; frame_length_pulse ##1 s_rd(`RCEF_OFF_FRAME_LEN) |=> rdata[0]; endproperty
    a_len: assert property (p_len) else $error("frame length flag");
    property p_done; energy_done_pulse ##1 s_rd(`RCEF_OFF_ED_DONE) |=> rdata[0]; endproperty
    a_done: assert property (p_done) else $error("energy done flag");
    property p_halt; energy_halt_pulse ##1 s_rd(`RCEF_OFF_ED_HALT) |=> rdata[0]; endproperty
    a_halt: assert property (p_halt) else $error("energy halt flag");
    property p_idle; channel_idle_pulse ##1 s_rd(`RCEF_OFF_CH_IDLE) |=> rdata[0]; endproperty
    a_idle: assert property (p_idle) else $error("channel idle flag");
    property p_busy; channel_busy_pulse ##1 s_rd(`RCEF_OFF_CH_BUSY) |=> rdata[0]; endproperty
    a_busy: assert property (p_busy) else $error("channel busy flag");
    property p_clr;
        wr && addr == `RCEF_OFF_CRC_GOOD && !wdata[0] && !crc_good_pulse
            ##1 s_rd(`RCEF_OFF_CRC_GOOD) |=> rdata == 32'h0;
    endproperty
    a_clr: assert property (p_clr) else $error("flag not cleared");
    property p_quiet; !rd |=> rdata == 32'h0; endproperty
    a_quiet: assert property (p_quiet) else $error("read data outside read");
endmodule
bind rcef_top rcef_chk rcef_chk_inst (.*);

// ===== tb/tb.sv
// self-checking bench of the radio event flag block
// assumes rcef_top and rcef_cfg.svh
`include "rcef_cfg.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, resetn = 0, wr = 0, rd = 0, irq, ei = 0;
    logic [11:0] addr = 12'h0;
    logic [31:0] wdata = 32'h0, rdata, er = 32'h0;
    logic [6:0] ev = 7'h0, mf = 7'h0, ms = 7'h0, me = 7'h0;
    int error_cnt = 0, n_tests = 0, cyc_cnt = 0;
    logic [11:0] ads [11] = '{`RCEF_OFF_CRC_GOOD, `RCEF_OFF_CRC_FAIL, `RCEF_OFF_FRAME_LEN,
        `RCEF_OFF_ED_DONE, `RCEF_OFF_ED_HALT, `RCEF_OFF_CH_IDLE, `RCEF_OFF_CH_BUSY,
        `RCEF_OFF_IRQ_STATUS, `RCEF_OFF_IRQ_CLEAR, `RCEF_OFF_IRQ_ENABLE, 12'h200};
    always #20 clk = ~clk;
    rcef_top rcef_top_inst (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .crc_good_pulse(ev[0]), .crc_fail_pulse(ev[1]),
        .frame_length_pulse(ev[2]), .energy_done_pulse(ev[3]), .energy_halt_pulse(ev[4]),
        .channel_idle_pulse(ev[5]), .channel_busy_pulse(ev[6]), .irq(irq));
    task end_of_test;
        $display("mismatches %0d of %0d checks", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task cyc(input logic [6:0] p, input logic w, input logic r, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge clk);
        ev <= p;
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= d;
        @(negedge clk);
        chk("rdata", er, rdata);
        chk("irq", {31'h0, ei}, {31'h0, irq});
        er = 32'h0;
        for (int i = 0; i < 7; i++) begin
            if (r && a == ads[i]) er = {31'h0, mf[i]};
            if (w && a == ads[i]) mf[i] = d[0];
        end
        if (r && a == `RCEF_OFF_IRQ_STATUS) er = {25'h0, ms};
        if (r && a == `RCEF_OFF_IRQ_ENABLE) er = {25'h0, me};
        if (w && a == `RCEF_OFF_IRQ_CLEAR) ms = ms & ~d[6:0];
        if (w && a == `RCEF_OFF_IRQ_ENABLE) me = d[6:0];
        mf = mf | p;
        ms = ms | p;
        ei = |(ms & me);
    endtask
    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt > 3000) begin
            error_cnt++;
            end_of_test();
        end
    end
    initial begin
        int op, k;
        void'($urandom(56));
        repeat (3) @(posedge clk);
        resetn <= 1'h1;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 11; i++) if (i != 8) cyc(7'h0, 0, 1, ads[i], 32'h0);
        cyc(7'h0, 1, 0, `RCEF_OFF_IRQ_ENABLE, 32'h7F);
        for (int i = 0; i < 7; i++) begin
            cyc(7'h1 << i, 0, 0, 12'h0, 32'h0);
            cyc(7'h0, 0, 1, ads[i], 32'h0);
            cyc(7'h0, 1, 0, `RCEF_OFF_IRQ_CLEAR, 32'h7F);
            cyc(7'h0, 1, 0, ads[i], 32'h0);
            cyc(7'h0, 0, 1, ads[i], 32'h0);
        end
        repeat (400) begin
            op = $urandom % 3;
            k = $urandom % 11;
            if (op == 2 && k == 8) op = 1;
            cyc(($urandom % 3 == 0) ? 7'h1 << ($urandom % 7) : 7'h0, op == 1, op == 2,
                ads[k], $urandom);
        end
        cyc(7'h0, 0, 0, 12'h0, 32'h0);
        end_of_test();
    end
endmodule
